// *** common/arf_regs.vh ***
// Summary of operation
// - Only last-result read clears data-ready
// - Data-ready rises only when result stored
// - Enabled channel end stores both results, data-ready
// - Enabled channel end with data-ready sets general overrun
// - Status read clears general overrun unless new
// - Channel read never blocks general overrun
// - Channel disable blocks both overruns for that channel's end
// - Channel or last read clears its end flag
// - Status read clears channel overrun despite end on cleared end flag
// - Channel read clears only its own flag
// - No end flag for channel disabled mid-conversion
// - Sleep selected, then start: sleep after conversion
`ifndef ARF_REGS_VH
`define ARF_REGS_VH
// ==========================================================
// Register offsets (byte addresses)
`define ARF_CR_OFF    12'h000
`define ARF_MR_OFF    12'h004
`define ARF_CHER_OFF  12'h010
`define ARF_CHDR_OFF  12'h014
`define ARF_CHSR_OFF  12'h018
`define ARF_SR_OFF    12'h01c
`define ARF_LAST_OFF  12'h020
`define ARF_IER_OFF   12'h024
`define ARF_IMR_OFF   12'h02c
`define ARF_CHRES0_OFF 12'h030
// ==========================================================
// Field positions
`define ARF_CR_START  1
`define ARF_MR_SLEEP  5
`define ARF_SR_OVR    8
`define ARF_SR_READY  16
`define ARF_SR_GOVR   17
`define ARF_SR_SLEEPING 18
// ==========================================================
// Sizes and reset values
`define ARF_NCH       8
`define ARF_DW        10
`define ARF_MR_RST    32'h0000_0000
`define ARF_IMR_RST   18'h00000
`endif

// *** hdl/arf_chan_slot.v ***
`include "arf_regs.vh"
// ==========================================================
// Per-channel result, end flag and overrun flag
module arf_chan_slot (
  // Clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // Events
  input  wire                 store,
  input  wire [`ARF_DW-1:0]   data_in,
  input  wire                 rd_clear,
  input  wire                 sr_read,
  // State
  output reg  [`ARF_DW-1:0]   result_reg,
  output reg                  eoc_reg,
  output reg                  ovr_reg
);
  // Result store and flag update; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= {`ARF_DW{1'b0}};
      eoc_reg    <= 1'b0;
      ovr_reg    <= 1'b0;
    end else begin
      if (store)
        result_reg <= data_in;
      if (store)
        eoc_reg <= 1'b1;
      else if (rd_clear)
        eoc_reg <= 1'b0;
      if (store && eoc_reg)
        ovr_reg <= 1'b1;
      else if (sr_read)
        ovr_reg <= 1'b0;
    end
  end
endmodule

// *** hdl/arf_flag_logic.v ***
`include "arf_regs.vh"
// ==========================================================
// Converter result and status flag logic, APB slave
module arf_flag_logic (
  // Clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // APB
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  // Conversion core
  input  wire                 conv_done,
  input  wire [2:0]           conv_chan,
  input  wire [`ARF_DW-1:0]   conv_data,
  output reg                  conv_start,
  output reg  [`ARF_NCH-1:0]  chan_enable,
  output reg                  core_sleep,
  // Interrupt
  output reg                  irq
);
  // ==========================================================
  // Decoding helpers
  function is_chres;
    input [11:0] a;
    begin
      is_chres = (a >= `ARF_CHRES0_OFF) && (a < `ARF_CHRES0_OFF + 12'h020) && (a[1:0] == 2'b00);
    end
  endfunction

  wire                 acc      = psel && penable && pready;
  wire                 wr       = acc && pwrite;
  wire                 rd       = acc && !pwrite;
  wire                 sr_rd    = rd && (paddr == `ARF_SR_OFF);
  wire                 last_rd  = rd && (paddr == `ARF_LAST_OFF);
  wire                 chres_rd = rd && is_chres(paddr);
  // Channel index counted from the first channel result offset, not from address zero
  wire [11:0]          res_off  = paddr - `ARF_CHRES0_OFF;
  wire [2:0]           res_ch   = res_off[4:2];

  reg                  ready_reg;
  reg                  govr_reg;
  reg                  mr_sleep_reg;
  reg                  armed_reg;
  reg  [2:0]           last_ch_reg;
  reg  [`ARF_DW-1:0]   last_data_reg;
  reg  [17:0]          imr_reg;
  reg  [`ARF_NCH-1:0]  chan_next;
  reg                  sleep_next;
  wire [`ARF_NCH-1:0]  eoc;
  wire [`ARF_NCH-1:0]  ovr;
  wire [`ARF_DW-1:0]   res [0:`ARF_NCH-1];
  wire [`ARF_NCH-1:0]  rd_clr;

  // Result stored only for a channel still enabled
  wire                 stored = conv_done && chan_enable[conv_chan];
  wire [17:0]          status = {govr_reg, ready_reg, ovr, eoc};

  // ==========================================================
  // Channel slots
  genvar g;
  generate
    for (g = 0; g < `ARF_NCH; g = g + 1) begin : gen_ch
      assign rd_clr[g] = (chres_rd && res_ch == g) || (last_rd && last_ch_reg == g);
      arf_chan_slot u_slot (
        .pclk       (pclk),
        .presetn    (presetn),
        .store      (stored && conv_chan == g),
        .data_in    (conv_data),
        .rd_clear   (rd_clr[g]),
        .sr_read    (sr_rd),
        .result_reg (res[g]),
        .eoc_reg    (eoc[g]),
        .ovr_reg    (ovr[g])
      );
    end
  endgenerate

  // Channel enable next value from enable/disable writes
  always @* begin
    chan_next = chan_enable;
    if (wr && paddr == `ARF_CHER_OFF)
      chan_next = chan_enable | pwdata[`ARF_NCH-1:0];
    if (wr && paddr == `ARF_CHDR_OFF)
      chan_next = chan_next & ~pwdata[`ARF_NCH-1:0];
  end

  // Sleep next value
  always @* begin
    sleep_next = core_sleep;
    if (!mr_sleep_reg)
      sleep_next = 1'b0;
    else if (armed_reg && stored)
      sleep_next = 1'b1;
  end

  // ==========================================================
  // Global flags, last result, control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg     <= 1'b0;
      govr_reg      <= 1'b0;
      last_ch_reg   <= 3'h0;
      last_data_reg <= {`ARF_DW{1'b0}};
      mr_sleep_reg  <= 1'b0;
      armed_reg     <= 1'b0;
      imr_reg       <= `ARF_IMR_RST;
      chan_enable   <= {`ARF_NCH{1'b0}};
      core_sleep    <= 1'b0;
      conv_start    <= 1'b0;
    end else begin
      // Data-ready: set on store wins; cleared only by last-result read
      if (stored) begin
        ready_reg     <= 1'b1;
        last_data_reg <= conv_data;
        last_ch_reg   <= conv_chan;
      end else if (last_rd)
        ready_reg <= 1'b0;
      // General overrun: set on store with data-ready wins; cleared by status read
      if (stored && ready_reg)
        govr_reg <= 1'b1;
      else if (sr_rd)
        govr_reg <= 1'b0;
      chan_enable <= chan_next;
      conv_start  <= wr && (paddr == `ARF_CR_OFF) && pwdata[`ARF_CR_START];
      if (wr && paddr == `ARF_MR_OFF)
        mr_sleep_reg <= pwdata[`ARF_MR_SLEEP];
      // Sleep armed by a start while sleep is selected
      if (!mr_sleep_reg)
        armed_reg <= 1'b0;
      else if (wr && paddr == `ARF_CR_OFF && pwdata[`ARF_CR_START])
        armed_reg <= 1'b1;
      else if (stored)
        armed_reg <= 1'b0;
      core_sleep <= sleep_next;
      if (wr && paddr == `ARF_IER_OFF)
        imr_reg <= pwdata[17:0];
    end
  end

  // ==========================================================
  // APB answer: no wait state, registered read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      irq     <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      irq     <= |(status & imr_reg);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ARF_MR_OFF:   prdata <= {26'h0, mr_sleep_reg, 5'h00};
          `ARF_CHSR_OFF: prdata <= {24'h0, chan_enable};
          `ARF_SR_OFF:   prdata <= {13'h0, core_sleep, status};
          `ARF_LAST_OFF: prdata <= {22'h0, last_data_reg};
          `ARF_IMR_OFF:  prdata <= {14'h0, imr_reg};
          default:       prdata <= is_chres(paddr) ? {22'h0, res[res_ch]} : 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// *** bench/arf_core_model.sv ***
`include "arf_regs.vh"
// ==========================================================
// Conversion core: ends conversions on command of the bench
module arf_core_model (
  // Clock
  input  wire logic                pclk,
  // End of conversion
  output logic                     conv_done,
  output logic [2:0]               conv_chan,
  output logic [`ARF_DW-1:0]       conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial begin
    conv_done = 1'b0;
    conv_chan = 3'h0;
    conv_data = 10'h000;
  end
  // One-cycle end pulse; data lines then show a changed value, not the last one
  task automatic finish(input logic [2:0] ch, input logic [`ARF_DW-1:0] d);
    conv_done <= 1'b1;
    conv_chan <= ch;
    conv_data <= d;
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_chan <= ~ch;
    conv_data <= ~d;
    @(posedge pclk);
  endtask
endmodule

// *** bench/arf_flag_logic_chk.sv ***
`include "arf_regs.vh"
// ==========================================================
// Port-level checks of the flag logic
module arf_flag_chk (
  // All ports of the block
  input wire logic                 pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata, prdata,
  input wire logic                 pready, pslverr, conv_done, conv_start, core_sleep, irq,
  input wire logic [2:0]           conv_chan,
  input wire logic [`ARF_DW-1:0]   conv_data,
  input wire logic [`ARF_NCH-1:0]  chan_enable
);
  logic [`ARF_DW-1:0] chan_q [`ARF_NCH];
  logic [`ARF_DW-1:0] last_q;
  wire                acc = psel && penable && pready;
  wire [11:0]         off = paddr - `ARF_CHRES0_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Copy of every stored result, per channel and last
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= '0;
      chan_q <= '{default: '0};
    end else if (conv_done && chan_enable[conv_chan]) begin
      last_q <= conv_data;
      chan_q[conv_chan] <= conv_data;
    end
  end
  pready_follow_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  pready_phase_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  no_error_a: assert property (!pslverr) else $error("error response");
  start_pulse_a: assert property (acc && pwrite && paddr == `ARF_CR_OFF && pwdata[1] |=> conv_start ##1 !conv_start)
    else $error("start pulse wrong");
  sleep_cause_a: assert property ($rose(core_sleep) |-> $past(conv_done)) else $error("sleep without end");
  last_data_a: assert property (acc && !pwrite && paddr == `ARF_LAST_OFF && !$past(conv_done)
    |-> prdata[9:0] == last_q) else $error("last result wrong");
  chan_data_a: assert property (acc && !pwrite && off < 12'h020 && !$past(conv_done)
    |-> prdata[9:0] == chan_q[off[4:2]]) else $error("channel result wrong");
  enable_set_a: assert property (acc && pwrite && paddr == `ARF_CHER_OFF
    |=> (chan_enable & $past(pwdata[7:0])) == $past(pwdata[7:0])) else $error("enable lost");
  disable_clr_a: assert property (acc && pwrite && paddr == `ARF_CHDR_OFF
    |=> (chan_enable & $past(pwdata[7:0])) == 8'h00) else $error("disable lost");
endmodule
bind arf_flag_logic arf_flag_chk arf_flag_chk_inst (.*);

// *** bench/test_arf_flag_logic.sv ***
`include "arf_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
// ==========================================================
// Testbench of the flag logic
module test_arf_flag_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, conv_done, conv_start, core_sleep, irq;
  logic [2:0] conv_chan;
  logic [`ARF_DW-1:0] conv_data;
  logic [`ARF_NCH-1:0] chan_enable;
  int error_cnt = 0, checks = 0;
  arf_flag_logic arf_flag_logic_inst (.*);
  arf_core_model arf_core_model_inst (.pclk(pclk), .conv_done(conv_done), .conv_chan(conv_chan),
    .conv_data(conv_data));
  initial forever #25 pclk = ~pclk;
  // One APB transfer, wait for ready bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin error_cnt++; tally_and_finish; end
    r = prdata; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0); `CHK(r, e) endtask
  task automatic fin(input logic [2:0] c, input logic [9:0] v); arf_core_model_inst.finish(c, v); endtask
  // Transfer whose access edge meets an end of conversion
  task automatic both(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] c,
    input logic [9:0] v);
    fork apb(w, a, d); begin @(posedge pclk); fin(c, v); end join
  endtask
  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d errors", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`ARF_MR_OFF, `ARF_MR_RST); rd(`ARF_IMR_OFF, 0); rd(12'h0f0, 0);
    apb(1, `ARF_CHER_OFF, 32'h0f); apb(1, `ARF_IER_OFF, 32'h10000);
    fin(2, 10'h155); rd(`ARF_SR_OFF, 32'h10004);
    `CHK(irq, 1'b1)
    rd(12'h034, 0); rd(12'h038, 10'h155);
    rd(`ARF_SR_OFF, 32'h10000);
    rd(`ARF_LAST_OFF, 10'h155); rd(`ARF_SR_OFF, 0);
    `CHK(irq, 1'b0)
    $display("store test done");
    fin(1, 10'h0aa); both(0, `ARF_SR_OFF, 0, 1, 10'h0ab); `CHK(r, 32'h10002)
    rd(`ARF_SR_OFF, 32'h30202);
    rd(`ARF_SR_OFF, 32'h10002);
    rd(`ARF_LAST_OFF, 10'h0ab); rd(`ARF_SR_OFF, 0);
    fin(3, 1); fin(3, 2); rd(12'h03c, 2);
    both(0, `ARF_SR_OFF, 0, 3, 3); `CHK(r, 32'h30800)
    rd(`ARF_SR_OFF, 32'h30008); rd(`ARF_LAST_OFF, 3);
    $display("overrun test done");
    apb(1, `ARF_CHDR_OFF, 32'h04); fin(0, 7);
    both(0, `ARF_LAST_OFF, 0, 2, 10'h3c3); `CHK(r, 7)
    rd(`ARF_SR_OFF, 0); rd(12'h038, 10'h155);
    fin(0, 10'h011); both(0, 12'h034, 0, 0, 10'h012); `CHK(r, 10'h0ab)
    rd(`ARF_SR_OFF, 32'h30101);
    both(1, `ARF_CHDR_OFF, 32'h02, 0, 10'h013); rd(`ARF_SR_OFF, 32'h30101);
    `CHK(chan_enable, 8'h09) rd(`ARF_LAST_OFF, 10'h013);
    $display("coincidence test done");
    apb(1, `ARF_MR_OFF, 32'h20); `CHK(core_sleep, 1'b0)
    apb(1, `ARF_CR_OFF, 32'h02); fin(0, 10'h014); `CHK(core_sleep, 1'b1)
    apb(1, `ARF_MR_OFF, 0); apb(1, `ARF_IER_OFF, 0); rd(`ARF_IMR_OFF, 0);
    `CHK(irq, 1'b0)
    $display("sleep test done");
    tally_and_finish;
  end
endmodule
